// ==== ccms_map.vh ====
`ifndef CCMS_MAP_VH
`define CCMS_MAP_VH

// Register byte offsets on the APB bus
`define CCMS_OFS_RCFG 12'h000
`define CCMS_OFS_CTRL 12'h004
`define CCMS_OFS_STAT 12'h008
`define CCMS_OFS_PHASE 12'h00c

// Reset values
`define CCMS_RCFG_RST 8'h00
`define CCMS_CTRL_RST 2'h1

// Clock source select field inside the reset configuration latch
`define CCMS_CSEL_MSB 7
`define CCMS_CSEL_LSB 5
`define CCMS_CSEL_MODE 7

// Control register fields
`define CCMS_CTRL_RUN 0
`define CCMS_CTRL_CLR 1

// Status register fields
`define CCMS_STAT_CPU 0
`define CCMS_STAT_PRESC 1
`define CCMS_STAT_PLL 2
`define CCMS_STAT_LRST 3
`define CCMS_STAT_RUN 4
`define CCMS_STAT_CSEL_LSB 8

// Phase measurement register fields
`define CCMS_PH_HI_LSB 0
`define CCMS_PH_LO_LSB 8
`define CCMS_PH_MIN_LSB 16

// Width of the phase length counters, in bits
`define CCMS_PH_W 8

// Pin synchroniser depth is fixed at three stages
`define CCMS_SYNC_STAGES 3

`endif

// ==== ccms_sync.v ====
`timescale 1ns/1ps
`default_nettype none

module ccms_sync #(
  parameter WIDTH = 10,
  parameter [WIDTH-1:0] RST_VAL = {WIDTH{1'b0}}
) (
  // Clock and reset
  input wire i_clk,
  input wire i_rst_n,
  // Asynchronous pin levels
  input wire [WIDTH-1:0] i_async,
  // Filtered levels
  output reg [WIDTH-1:0] o_level
);

  reg [WIDTH-1:0] stage1;
  reg [WIDTH-1:0] stage2;
  reg [WIDTH-1:0] stage3;
  integer i;

  // A bit moves only once the second and third stages agree
  always @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      stage1 <= RST_VAL;
      stage2 <= RST_VAL;
      stage3 <= RST_VAL;
      o_level <= RST_VAL;
    end else begin
      stage1 <= i_async;
      stage2 <= stage1;
      stage3 <= stage2;
      for (i = 0; i < WIDTH; i = i + 1) begin
        if (stage2[i] == stage3[i]) begin
          o_level[i] <= stage3[i];
        end
      end
    end
  end

endmodule // ccms_sync

`default_nettype wire

// ==== ccms_top.v ====
// Contract
// - Both CPU clock edges launch actions; rise and fall pulses are given.
// - Long hardware reset copies port0 upper byte into the latch bit for bit.
// - Latch bits seven to five hold the clock source select field.
// - Select top bit zero: PLL off, CPU clock follows oscillator 1:1.
// - Select top bit one: CPU clock is oscillator divided by two.
// - Divided mode: each CPU clock phase lasts one oscillator period.
// - Direct mode: CPU phases follow oscillator high and low times.
// - Direct mode: two consecutive phases together span one oscillator period.
`timescale 1ns/1ps
`default_nettype none
`include "ccms_map.vh"

module ccms_top #(
  parameter PH_W = `CCMS_PH_W
) (
  // Clock and reset
  input wire I_CLK,
  input wire I_RST_N,
  // Oscillator and reset configuration pins
  input wire I_OSC_INPUT_PIN,
  input wire [7:0] I_PORT0_UPPER_BYTE,
  input wire I_LONG_HW_RESET,
  // APB slave
  input wire I_PSEL,
  input wire I_PENABLE,
  input wire I_PWRITE,
  input wire [11:0] I_PADDR,
  input wire [31:0] I_PWDATA,
  output reg [31:0] O_PRDATA,
  output reg O_PREADY,
  output reg O_PSLVERR,
  // Generated CPU clock and its edge strobes
  output reg O_CPU_CLOCK,
  output reg O_CPU_RISE,
  output reg O_CPU_FALL,
  // Mode indication
  output reg O_PLL_ENABLE,
  output reg O_PRESCALE_MODE
);

  // Saturating increment of a phase length counter
  function [PH_W-1:0] sat_inc;
    input [PH_W-1:0] v;
    begin
      if (&v) begin
        sat_inc = v;
      end else begin
        sat_inc = v + {{(PH_W-1){1'b0}}, 1'b1};
      end
    end
  endfunction

  // True when an APB address names a mapped register
  function is_mapped;
    input [11:0] a;
    begin
      is_mapped = (a == `CCMS_OFS_RCFG) || (a == `CCMS_OFS_CTRL) ||
        (a == `CCMS_OFS_STAT) || (a == `CCMS_OFS_PHASE);
    end
  endfunction

  // True when an APB address names the control register
  function is_ctrl;
    input [11:0] a;
    begin
      is_ctrl = (a == `CCMS_OFS_CTRL);
    end
  endfunction

  wire [9:0] pin_level;
  wire osc_level;
  wire [7:0] port_level;
  wire long_reset;

  reg [7:0] reset_config_latch_high;
  reg [1:0] ctrl;
  reg osc_prev;
  reg cpu_prev;
  reg [PH_W-1:0] phase_cnt;
  reg [PH_W-1:0] hi_len;
  reg [PH_W-1:0] lo_len;
  reg [PH_W-1:0] min_len;
  reg next_cpu;
  reg [31:0] next_rdata;

  wire [2:0] clock_source_select;
  wire prescale;
  wire osc_rise;
  wire apb_access;
  wire apb_done;
  wire apb_write;
  wire clr_meas;
  wire apb_take;
  wire ctrl_write;
  wire cpu_edge;
  reg [1:0] apb_state;
  reg [1:0] next_apb_state;

  // APB answer sequencing states
  localparam [1:0] APB_IDLE = 2'b01;
  localparam [1:0] APB_ANSWER = 2'b10;

  ccms_sync #(
    .WIDTH(10),
    .RST_VAL(10'h000)
  ) u_sync (
    .i_clk(I_CLK),
    .i_rst_n(I_RST_N),
    .i_async({I_LONG_HW_RESET, I_PORT0_UPPER_BYTE, I_OSC_INPUT_PIN}),
    .o_level(pin_level)
  );

  assign osc_level = pin_level[0];
  assign port_level = pin_level[8:1];
  assign long_reset = pin_level[9];

  assign clock_source_select =
    reset_config_latch_high[`CCMS_CSEL_MSB:`CCMS_CSEL_LSB];
  // top bit alone picks the divider
  assign prescale = reset_config_latch_high[`CCMS_CSEL_MODE];
  assign osc_rise = osc_level & ~osc_prev;

  // capture port levels during long reset
  // hold selection until next long reset or system reset
  always @(posedge I_CLK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      reset_config_latch_high <= `CCMS_RCFG_RST;
    end else if (long_reset) begin
      reset_config_latch_high <= port_level;
    end
  end

  // CPU clock next value
  always @* begin
    next_cpu = O_CPU_CLOCK;
    if (prescale) begin
      if (osc_rise) begin
        next_cpu = ~O_CPU_CLOCK;
      end
    end else begin
      // phases follow oscillator high and low
      // a high plus low pair is one oscillator period
      next_cpu = osc_level;
    end
    // Stopping lets the clock fall but never rise, so no runt phase
    if (!ctrl[`CCMS_CTRL_RUN]) begin
      next_cpu = O_CPU_CLOCK & next_cpu;
    end
  end

  always @(posedge I_CLK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      osc_prev <= 1'b0;
      O_CPU_CLOCK <= 1'b0;
      O_CPU_RISE <= 1'b0;
      O_CPU_FALL <= 1'b0;
      O_PLL_ENABLE <= 1'b0;
      O_PRESCALE_MODE <= 1'b0;
    end else begin
      osc_prev <= osc_level;
      O_CPU_CLOCK <= next_cpu;
      // strobes for both CPU clock edges
      O_CPU_RISE <= next_cpu & ~O_CPU_CLOCK;
      O_CPU_FALL <= ~next_cpu & O_CPU_CLOCK;
      O_PLL_ENABLE <= 1'b0;
      O_PRESCALE_MODE <= prescale;
    end
  end

  // Phase length measurement in system clock cycles
  assign ctrl_write = apb_write && is_ctrl(I_PADDR);
  assign clr_meas = ctrl_write && I_PWDATA[`CCMS_CTRL_CLR];
  // Generated clock edge, seen one cycle after it is driven
  assign cpu_edge = (O_CPU_CLOCK != cpu_prev);

  always @(posedge I_CLK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      cpu_prev <= 1'b0;
      phase_cnt <= {PH_W{1'b0}};
      hi_len <= {PH_W{1'b0}};
      lo_len <= {PH_W{1'b0}};
      min_len <= {PH_W{1'b1}};
    end else begin
      cpu_prev <= O_CPU_CLOCK;
      if (cpu_edge) begin
        phase_cnt <= {{(PH_W-1){1'b0}}, 1'b1};
        if (cpu_prev) begin
          hi_len <= phase_cnt;
        end else begin
          lo_len <= phase_cnt;
        end
      end else begin
        phase_cnt <= sat_inc(phase_cnt);
      end
      // Clear wins for the shortest phase; a new edge restarts it
      if (ctrl[`CCMS_CTRL_CLR]) begin
        min_len <= {PH_W{1'b1}};
      end else if (cpu_edge && (phase_cnt != {PH_W{1'b0}}) &&
          (phase_cnt < min_len)) begin
        min_len <= phase_cnt;
      end
    end
  end

  // APB slave: one wait state, answer in the second access cycle
  assign apb_access = I_PSEL & I_PENABLE;
  assign apb_done = apb_access & O_PREADY;
  assign apb_write = apb_done & I_PWRITE;
  assign apb_take = apb_access && (apb_state == APB_IDLE);

  always @* begin
    next_apb_state = APB_IDLE;
    case (apb_state)
      APB_IDLE: begin
        if (apb_access) begin
          next_apb_state = APB_ANSWER;
        end
      end
      APB_ANSWER: begin
        next_apb_state = APB_IDLE;
      end
      default: begin
        next_apb_state = APB_IDLE;
      end
    endcase
  end

  always @(posedge I_CLK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      apb_state <= APB_IDLE;
    end else begin
      apb_state <= next_apb_state;
    end
  end

  always @(posedge I_CLK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      ctrl <= `CCMS_CTRL_RST;
    end else begin
      // Clear bit lives one cycle only; the run bit is stored
      ctrl[`CCMS_CTRL_CLR] <= clr_meas;
      if (ctrl_write) begin
        ctrl[`CCMS_CTRL_RUN] <= I_PWDATA[`CCMS_CTRL_RUN];
      end
    end
  end

  always @* begin
    next_rdata = 32'h00000000;
    case (I_PADDR)
      `CCMS_OFS_RCFG: begin
        next_rdata[7:0] = reset_config_latch_high;
      end
      `CCMS_OFS_CTRL: begin
        next_rdata[`CCMS_CTRL_RUN] = ctrl[`CCMS_CTRL_RUN];
      end
      `CCMS_OFS_STAT: begin
        next_rdata[`CCMS_STAT_CPU] = O_CPU_CLOCK;
        next_rdata[`CCMS_STAT_PRESC] = prescale;
        next_rdata[`CCMS_STAT_PLL] = O_PLL_ENABLE;
        next_rdata[`CCMS_STAT_LRST] = long_reset;
        next_rdata[`CCMS_STAT_RUN] = ctrl[`CCMS_CTRL_RUN];
        next_rdata[`CCMS_STAT_CSEL_LSB +: 3] = clock_source_select;
      end
      `CCMS_OFS_PHASE: begin
        next_rdata[`CCMS_PH_HI_LSB +: PH_W] = hi_len;
        next_rdata[`CCMS_PH_LO_LSB +: PH_W] = lo_len;
        next_rdata[`CCMS_PH_MIN_LSB +: PH_W] = min_len;
      end
      default: begin
        next_rdata = 32'h00000000;
      end
    endcase
  end

  always @(posedge I_CLK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      O_PREADY <= 1'b0;
      O_PRDATA <= 32'h00000000;
      O_PSLVERR <= 1'b0;
    end else begin
      O_PREADY <= (next_apb_state == APB_ANSWER);
      if (apb_take) begin
        O_PRDATA <= I_PWRITE ? 32'h00000000 : next_rdata;
        O_PSLVERR <= ~is_mapped(I_PADDR) |
          (I_PWRITE & ~is_ctrl(I_PADDR));
      end else begin
        O_PRDATA <= 32'h00000000;
        O_PSLVERR <= 1'b0;
      end
    end
  end

endmodule // ccms_top

`default_nettype wire

// ==== ccms_monitor.sv ====
`timescale 1ns/1ps
`default_nettype none

module ccms_monitor (
  // Clock and reset
  input wire logic I_CLK,
  input wire logic I_RST_N,
  // Watched pins
  input wire logic I_OSC_INPUT_PIN,
  input wire logic I_LONG_HW_RESET,
  input wire logic O_CPU_CLOCK,
  input wire logic O_CPU_RISE,
  input wire logic O_CPU_FALL,
  input wire logic O_PRESCALE_MODE
);
  default clocking cb @(posedge I_CLK); endclocking
  default disable iff (!I_RST_N);
  a_rise_strobe:
    assert property (O_CPU_RISE == $rose(O_CPU_CLOCK)) else $error("rise");
  a_fall_strobe:
    assert property (O_CPU_FALL == $fell(O_CPU_CLOCK)) else $error("fall");
  a_strobe_single:
    assert property ((O_CPU_RISE || O_CPU_FALL) |=> !O_CPU_RISE && !O_CPU_FALL)
    else $error("strobe width");
  a_div_toggle:
    assert property ($rose(I_OSC_INPUT_PIN) && O_PRESCALE_MODE |->
      ##[3:6] (O_CPU_RISE || O_CPU_FALL)) else $error("no toggle");
  a_div_phase:
    assert property (O_PRESCALE_MODE && O_CPU_RISE |=> O_CPU_CLOCK [*3])
    else $error("short phase");
  a_direct_rise:
    assert property ($rose(I_OSC_INPUT_PIN) && !O_PRESCALE_MODE |->
      ##[3:6] O_CPU_RISE) else $error("no rise");
  a_direct_fall:
    assert property ($fell(I_OSC_INPUT_PIN) && !O_PRESCALE_MODE |->
      ##[3:6] O_CPU_FALL) else $error("no fall");
  a_latch_hold:
    assert property (!I_LONG_HW_RESET [*8] |-> $stable(O_PRESCALE_MODE))
    else $error("mode moved");
  c_div_rise: cover property (O_PRESCALE_MODE && O_CPU_RISE);
  c_dir_fall: cover property (!O_PRESCALE_MODE && O_CPU_FALL);
  c_long_end: cover property ($fell(I_LONG_HW_RESET));
endmodule // ccms_monitor

bind ccms_top ccms_monitor i_mon (.I_CLK(I_CLK), .I_RST_N(I_RST_N),
  .I_OSC_INPUT_PIN(I_OSC_INPUT_PIN), .I_LONG_HW_RESET(I_LONG_HW_RESET),
  .O_CPU_CLOCK(O_CPU_CLOCK), .O_CPU_RISE(O_CPU_RISE),
  .O_CPU_FALL(O_CPU_FALL), .O_PRESCALE_MODE(O_PRESCALE_MODE));

`default_nettype wire

// ==== ccms_osc_model.sv ====
`timescale 1ns/1ps
`default_nettype none

module ccms_osc_model #(
  parameter int HI_NS = 30,
  parameter int LO_NS = 50
) (
  // Run control
  input wire logic i_run,
  // Oscillator pin
  output logic o_osc
);
  // uneven duty, stands low when stopped
  initial begin
    o_osc = 1'b0;
    forever begin
      wait (i_run === 1'b1);
      #3 o_osc = 1'b1;
      #(HI_NS) o_osc = 1'b0;
      #(LO_NS - 3);
    end
  end
endmodule // ccms_osc_model

`default_nettype wire

// ==== tb.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "ccms_map.vh"
`define CHK(nm, exp, got) begin cmp_count++; if ((got) !== (exp)) begin \
  mismatches++; $display("unexpected %s exp %0h got %0h", nm, exp, got); \
  end end

module tb;
  localparam int HI = 3;
  localparam int LO = 5;
  localparam logic [7:0] DIV = 8'(HI + LO);
  logic clk, rst_n, osc, run, lrst, psel, pen, pwr, err, pready, perr;
  logic cclk, crise, cfall, pll, presc;
  logic [7:0] p0;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  int mismatches, cmp_count, cyc, hi, lo;

  ccms_top i_dut (.I_CLK(clk), .I_RST_N(rst_n), .I_OSC_INPUT_PIN(osc),
    .I_PORT0_UPPER_BYTE(p0), .I_LONG_HW_RESET(lrst), .I_PSEL(psel),
    .I_PENABLE(pen), .I_PWRITE(pwr), .I_PADDR(paddr), .I_PWDATA(pwdata),
    .O_PRDATA(prdata), .O_PREADY(pready), .O_PSLVERR(perr),
    .O_CPU_CLOCK(cclk), .O_CPU_RISE(crise), .O_CPU_FALL(cfall),
    .O_PLL_ENABLE(pll), .O_PRESCALE_MODE(presc));
  ccms_osc_model #(.HI_NS(HI * 10), .LO_NS(LO * 10)) i_osc (.i_run(run),
    .o_osc(osc));

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  task automatic tally_and_finish;
    if (mismatches == 0 && cmp_count > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  always @(posedge clk) begin
    cyc++;
    if (cyc == 5000) begin
      mismatches++;
      tally_and_finish();
    end
  end

  // Request held until pready is sampled high; answer taken at that edge
  task automatic apb(input logic w, input logic [11:0] a,
    input logic [31:0] d = 32'h0);
    psel <= 1'b1;
    pwr <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    pen <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1)
      @(posedge clk);
    rd = prdata;
    err = perr;
    psel <= 1'b0;
    pen <= 1'b0;
    @(posedge clk);
  endtask

  task automatic check_mode(input logic [7:0] v);
    apb(1'b0, `CCMS_OFS_RCFG);
    `CHK("latch", {24'h0, v}, rd)
    apb(1'b0, `CCMS_OFS_STAT);
    `CHK("select", v[7:5], rd[10:8])
    `CHK("divided", v[7], presc)
    `CHK("pll", 1'b0, pll)
  endtask

  task automatic meas;
    hi = 0;
    lo = 0;
    @(negedge clk);
    while (crise !== 1'b1)
      @(negedge clk);
    do begin
      @(negedge clk);
      hi++;
    end while (cfall !== 1'b1);
    do begin
      @(negedge clk);
      lo++;
    end while (crise !== 1'b1);
    @(posedge clk);
  endtask

  // Oscillator held still around the mode change
  task automatic long_reset(input logic [7:0] v);
    run <= 1'b0;
    repeat (12) @(posedge clk);
    p0 <= v;
    lrst <= 1'b1;
    repeat (10) @(posedge clk);
    lrst <= 1'b0;
    repeat (10) @(posedge clk);
    p0 <= ~v;
  endtask

  initial begin
    rst_n = 1'b0;
    run = 1'b0;
    lrst = 1'b0;
    p0 = 8'h00;
    psel = 1'b0;
    pen = 1'b0;
    pwr = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0;
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    check_mode(8'h00);
    apb(1'b0, `CCMS_OFS_CTRL);
    `CHK("run", 32'h1, rd)
    apb(1'b0, 12'h010);
    `CHK("unmapped", 1'b1, err)
    long_reset(8'h5a);
    check_mode(8'h5a);
    run <= 1'b1;
    meas();
    `CHK("dir high", HI, hi)
    `CHK("dir low", LO, lo)
    `CHK("dir pair", HI + LO, hi + lo)
    apb(1'b0, `CCMS_OFS_PHASE);
    `CHK("dir phases", {8'h00, 8'(HI), 8'(LO), 8'(HI)}, rd)
    apb(1'b1, `CCMS_OFS_RCFG, 32'hff);
    `CHK("ro write", 1'b1, err)
    check_mode(8'h5a);
    long_reset(8'hb3);
    check_mode(8'hb3);
    run <= 1'b1;
    meas();
    `CHK("div high", HI + LO, hi)
    `CHK("div low", HI + LO, lo)
    apb(1'b0, `CCMS_OFS_PHASE);
    `CHK("div phases", {8'h00, 8'(HI), DIV, DIV}, rd)
    run <= 1'b0;
    repeat (12) @(posedge clk);
    apb(1'b1, `CCMS_OFS_CTRL, 32'h3);
    `CHK("ctrl write", 1'b0, err)
    apb(1'b0, `CCMS_OFS_PHASE);
    `CHK("cleared", {8'h00, 8'hff, DIV, DIV}, rd)
    apb(1'b1, `CCMS_OFS_CTRL, 32'h0);
    apb(1'b0, `CCMS_OFS_STAT);
    `CHK("stopped", 1'b0, rd[`CCMS_STAT_RUN])
    rst_n <= 1'b0;
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    check_mode(8'h00);
    apb(1'b0, `CCMS_OFS_CTRL);
    `CHK("run reset", 32'h1, rd)
    tally_and_finish();
  end
endmodule // tb

`default_nettype wire
